/* rtl/emc_pkg.sv */
// Shared constants and types of the external memory pin control block.
// Assumes one core clock; all slower rates are one-cycle enables.
package emc_pkg;
  // Access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD   = 3'b011,
    ST_HOST   = 3'b100
  } emc_state_t;
  // Memory type of a space
  localparam logic [1:0] TY_ASYNC = 2'h0;
  localparam logic [1:0] TY_SDRAM = 2'h1;
  localparam logic [1:0] TY_SYNC = 2'h2;
  // Memory width codes: 8, 16, 32, 64 bits
  localparam logic [1:0] WD_8 = 2'h0;
  localparam logic [1:0] WD_64 = 2'h3;
  // Word-address bits 31:30 that mark an external space; bits 29:28 pick the space
  localparam logic [1:0] SPACE_TOP = 2'h2;
  localparam int SPACE_LSB = 28;
  // Clock source strap codes and selected sources
  localparam logic [1:0] STRAP_CPU4 = 2'h1;
  localparam logic [1:0] STRAP_CPU6 = 2'h2;
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_CPU4 = 2'h1;
  localparam logic [1:0] SRC_CPU6 = 2'h2;
  // Divider select codes for the divided output clock
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_4 = 2'h2;
  // Least strobe length of an asynchronous access, in cycles
  localparam logic [1:0] ASYNC_STROBE_CYC = 2'h2;
  // Reset values
  localparam logic [7:0] BE_IDLE = 8'hff;
  localparam logic [3:0] CE_IDLE = 4'hf;
endpackage

/* rtl/emc_clk_div.sv */
// Divided memory output clock enable: one pulse every 1, 2 or 4 cycles.
// Assumes the core clock is the selected memory input clock.
`timescale 1ns/10ps
module emc_clk_div (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Divisor select
  input wire logic [1:0] i_div_sel,
  // Divided clock enable
  output logic o_tick
);
  import emc_pkg::*;

  // Divider state
  typedef struct packed {
    logic [1:0] cnt;
    logic tick;
  } emc_div_t;

  emc_div_t r;
  emc_div_t n;
  logic [1:0] last;

  // Terminal count from the divisor select
  always_comb begin
    case (i_div_sel)
      DIV_2: last = 2'h1;
      DIV_4: last = 2'h3;
      default: last = 2'h0;
    endcase
  end

  // Count up and pulse at terminal count
  always_comb begin
    n = r;
    if (r.cnt >= last) begin
      n.cnt = 2'h0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 2'h1;
      n.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_tick = r.tick;

  // Divide by four: a pulse with the select held at four for the next three cycles
  sequence s_div4_run;
    (o_tick && i_div_sel == DIV_4) ##1 (i_div_sel == DIV_4) [*3];
  endsequence
  // Three quiet cycles after the pulse, then the next pulse
  sequence s_div4_gap;
    !o_tick && !$past(o_tick) && !$past(o_tick, 2) ##1 o_tick;
  endsequence
  property p_div4;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      s_div4_run |-> s_div4_gap;
  endproperty
  a_div4: assert property (p_div4) else $error("divided clock period wrong");
endmodule

/* rtl/emc_pin_ctrl.sv */
// External memory pin control: space enables, byte selects, shared strobes,
// host bus arbitration, clock source strap capture and output clock enables.
// Assumes i_core_clk is the selected memory input clock and inputs are synchronous.
`timescale 1ns/10ps
module emc_pin_ctrl (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Access request from the core
  input wire logic i_acc_req,
  input wire logic i_acc_write,
  input wire logic [31:0] i_ext_word_addr,
  input wire logic [2:0] i_acc_byte_lo,
  input wire logic [1:0] i_acc_size,
  input wire logic i_acc_periph,
  output logic o_acc_ready,
  output logic o_acc_done,
  // Space configuration, two bits of type and one read select per space
  input wire logic [7:0] i_space_types,
  input wire logic [3:0] i_read_en_select,
  input wire logic [1:0] i_mem_width,
  // Ready from slow asynchronous targets
  input wire logic i_async_ready_in,
  // Host arbitration
  input wire logic i_host_hold_req,
  output logic o_host_hold_ack,
  output logic o_own_bus_req,
  output logic o_bus_drive_en,
  // Clock straps and divider select
  input wire logic [1:0] i_clk_strap,
  input wire logic [1:0] i_clk_div_sel,
  output logic [1:0] o_clk_src_sel,
  output logic o_mem_clk_out_full,
  output logic o_mem_clk_out_div,
  // Memory pins, active low
  output logic [3:0] o_space_enable_out_n,
  output logic [7:0] o_byte_select_out_n,
  output logic o_shared_rd_strobe_n,
  output logic o_shared_oe_strobe_n,
  output logic o_shared_we_strobe_n,
  output logic o_fifo_space_out_en_n,
  output logic o_periph_transfer_strobe_n
);
  import emc_pkg::*;

  // Whole state of the block
  typedef struct packed {
    emc_state_t st;
    logic [1:0] cnt;
    logic wr;
    logic [1:0] sp;
    logic [1:0] ty;
    logic rensel;
    logic per;
    logic [7:0] be;
    logic strap_done;
    logic [1:0] clk_src;
    logic full_en;
    logic [3:0] ce_n;
    logic [7:0] be_n;
    logic rd_n;
    logic oe_n;
    logic we_n;
    logic fifo_oe_n;
    logic pdt_n;
  } emc_ctrl_t;
  emc_ctrl_t r;
  emc_ctrl_t n;
  logic acc_valid; // Address falls in an external space
  logic [1:0] acc_sp; // Space picked by address bits 29:28
  logic [7:0] lane_mask; // Lanes touched by this access
  logic done;
  // Space decode from the top word-address bits
  assign acc_sp = i_ext_word_addr[SPACE_LSB+1:SPACE_LSB];
  assign acc_valid = i_ext_word_addr[31:30] == SPACE_TOP;
  // Lane mask from width, low address and size
  always_comb begin
    logic [3:0] lanes;
    logic [3:0] sz;
    logic [2:0] off;
    logic [15:0] m;
    lanes = 4'h1 << i_mem_width;
    sz = 4'h1 << i_acc_size;
    if (sz > lanes) begin
      sz = lanes;
    end
    off = i_acc_byte_lo & 3'(lanes - 4'h1);
    m = 16'(((16'h1 << sz) - 16'h1) << off);
    if (!i_acc_write) begin
      m = 16'((16'h1 << lanes) - 16'h1);
    end
    lane_mask = m[7:0] & 8'(((16'h1 << lanes) - 16'h1));
  end
  // Ready to take an access when idle, straps caught, the address in an external space and no host wants the bus
  assign o_acc_ready = r.st == ST_IDLE && !i_host_hold_req && acc_valid && r.strap_done;
  // Next state and next pin values
  always_comb begin
    n = r;
    done = 1'b0;
    // Catch the straps once, on the first cycle after reset release
    if (!r.strap_done) begin
      n.strap_done = 1'b1;
      case (i_clk_strap)
        STRAP_CPU4: n.clk_src = SRC_CPU4;
        STRAP_CPU6: n.clk_src = SRC_CPU6;
        default: n.clk_src = SRC_PIN;
      endcase
    end
    n.full_en = 1'b1;
    case (r.st)
      // Take host first, else an access
      ST_IDLE: begin
        if (i_host_hold_req) begin
          n.st = ST_HOST;
        end else if (o_acc_ready && i_acc_req) begin
          n.st = ST_SETUP;
          n.wr = i_acc_write;
          n.sp = acc_sp;
          n.ty = i_space_types[2*acc_sp +: 2];
          n.rensel = i_read_en_select[acc_sp];
          n.per = i_acc_periph;
          n.be = lane_mask;
        end
      end
      // Address setup, SDRAM row strobe
      ST_SETUP: begin
        n.st = ST_STROBE;
        n.cnt = 2'h1;
      end
      // Strobe phase; asynchronous targets may stretch it
      ST_STROBE: begin
        if (r.ty == TY_ASYNC && (r.cnt < ASYNC_STROBE_CYC || !i_async_ready_in)) begin
          n.cnt = (r.cnt < ASYNC_STROBE_CYC) ? r.cnt + 2'h1 : r.cnt;
        end else begin
          n.st = ST_HOLD;
        end
      end
      // Hold phase ends the access
      ST_HOLD: begin
        n.st = ST_IDLE;
        done = 1'b1;
      end
      // Bus granted to the host until it drops its request
      ST_HOST: begin
        if (!i_host_hold_req) begin
          n.st = ST_IDLE;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // Pin values for the next state
    n.ce_n = CE_IDLE;
    n.be_n = BE_IDLE;
    n.rd_n = 1'b1;
    n.oe_n = 1'b1;
    n.we_n = 1'b1;
    n.fifo_oe_n = 1'b1;
    n.pdt_n = 1'b1;
    if (n.st == ST_SETUP || n.st == ST_STROBE || n.st == ST_HOLD) begin
      n.ce_n[n.sp] = 1'b0;
      n.be_n = ~n.be;
      n.pdt_n = !n.per;
    end
    if (n.st == ST_SETUP && n.ty == TY_SDRAM) begin
      n.oe_n = 1'b0;
    end
    if (n.st == ST_STROBE) begin
      case (n.ty)
        TY_ASYNC: begin
          n.rd_n = n.wr;
          n.oe_n = n.wr;
          n.we_n = !n.wr;
        end
        TY_SDRAM: begin
          n.rd_n = 1'b0;
          n.we_n = !n.wr;
        end
        TY_SYNC: begin
          n.rd_n = n.rensel ? n.wr : 1'b0;
          n.oe_n = n.wr;
          n.we_n = !n.wr;
          n.fifo_oe_n = !(n.sp == 2'h3 && !n.wr);
        end
        default: n.rd_n = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      r <= '{st: ST_IDLE, clk_src: SRC_PIN, ce_n: CE_IDLE, be_n: BE_IDLE,
             rd_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, fifo_oe_n: 1'b1, pdt_n: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end
  // Divided output clock enable
  emc_clk_div u_div (
    .i_core_clk (i_core_clk),
    .i_reset_n (i_reset_n),
    .i_div_sel (i_clk_div_sel),
    .o_tick (o_mem_clk_out_div)
  );
  // Output assignments
  assign o_acc_done = done;
  assign o_host_hold_ack = r.st == ST_HOST;
  assign o_bus_drive_en = r.st != ST_HOST;
  assign o_own_bus_req = r.st == ST_HOST && i_acc_req;
  assign o_clk_src_sel = r.clk_src;
  assign o_mem_clk_out_full = r.full_en;
  assign o_space_enable_out_n = r.ce_n;
  assign o_byte_select_out_n = r.be_n;
  assign o_shared_rd_strobe_n = r.rd_n;
  assign o_shared_oe_strobe_n = r.oe_n;
  assign o_shared_we_strobe_n = r.we_n;
  assign o_fifo_space_out_en_n = r.fifo_oe_n;
  assign o_periph_transfer_strobe_n = r.pdt_n;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // Phases of an access
  sequence s_taken;
    o_acc_ready && i_acc_req && !i_host_hold_req;
  endsequence
  sequence s_setup_strobe;
    r.st == ST_SETUP ##1 r.st == ST_STROBE;
  endsequence
  property p_onehot_ce;
    $onehot0(~o_space_enable_out_n);
  endproperty
  a_onehot_ce: assert property (p_onehot_ce) else $error("two space enables low");
  property p_ce_decode;
    s_taken |=> !o_space_enable_out_n[$past(acc_sp)];
  endproperty
  a_ce_decode: assert property (p_ce_decode) else $error("wrong space enabled");
  property p_ack_release;
    o_host_hold_ack |-> !o_bus_drive_en && o_space_enable_out_n == CE_IDLE;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("bus driven during grant");
  property p_ack_after_idle;
    $rose(o_host_hold_ack) |-> $past(r.st) == ST_IDLE && $past(i_host_hold_req);
  endproperty
  a_ack_after_idle: assert property (p_ack_after_idle) else $error("grant during access");
  property p_ack_drop;
    o_host_hold_ack && !i_host_hold_req |=> !o_host_hold_ack && o_bus_drive_en;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("grant not withdrawn");
  property p_own_req;
    o_host_hold_ack && i_acc_req |-> o_own_bus_req;
  endproperty
  a_own_req: assert property (p_own_req) else $error("missing own bus request");
  property p_access_walk;
    s_taken |=> s_setup_strobe;
  endproperty
  a_access_walk: assert property (p_access_walk) else $error("access phases out of order");
  property p_wait_ready;
    r.st == ST_STROBE && r.ty == TY_ASYNC && r.cnt == ASYNC_STROBE_CYC && !i_async_ready_in
      |=> r.st == ST_STROBE && !o_space_enable_out_n[r.sp];
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("not-ready target cut short");
  property p_sync_addr;
    r.st == ST_STROBE && r.ty == TY_SYNC && !r.rensel |-> !o_shared_rd_strobe_n;
  endproperty
  a_sync_addr: assert property (p_sync_addr) else $error("address strobe missing");
  property p_sdram_row;
    r.st == ST_SETUP && r.ty == TY_SDRAM |-> !o_shared_oe_strobe_n && o_shared_rd_strobe_n;
  endproperty
  a_sdram_row: assert property (p_sdram_row) else $error("row strobe wrong");
  property p_fifo_oe;
    !o_fifo_space_out_en_n |-> !o_space_enable_out_n[3] && o_shared_we_strobe_n;
  endproperty
  a_fifo_oe: assert property (p_fifo_oe) else $error("fifo enable outside space 3");
  property p_full_clk;
    $past(i_reset_n) && $past(i_reset_n, 2) |-> o_mem_clk_out_full;
  endproperty
  a_full_clk: assert property (p_full_clk) else $error("full clock enable low");
endmodule

/* test/emc_mem_model.sv */
// Slow asynchronous target: stretches strobes on async spaces by holding ready low.
// Assumes ready has a pull-up, so it reads high whenever no target holds it low.
`timescale 1ns/10ps
module emc_mem_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Pins seen on the memory side
  input wire logic [3:0] i_space_enable_out_n,
  input wire logic [7:0] i_space_types,
  input wire logic i_rd_n,
  input wire logic i_we_n,
  // Wait cycles to insert
  input wire logic [3:0] i_wait_cyc,
  output logic o_async_ready_in
);
  logic act; // Strobe live on an async space
  logic [3:0] cnt; // Strobe cycles seen so far
  // Find whether the selected space is asynchronous and strobed
  always_comb begin
    act = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (!i_space_enable_out_n[k] && i_space_types[2*k +: 2] == 2'h0 && (!i_rd_n || !i_we_n)) begin
        act = 1'b1;
      end
    end
  end
  // Count strobe cycles, restart once released
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || !act) begin
      cnt <= 4'h0;
    end else if (cnt != 4'hf) begin
      cnt <= cnt + 4'h1;
    end
  end
  // Not ready until enough cycles pass; the pull-up holds it high otherwise
  assign o_async_ready_in = !(act && cnt < i_wait_cyc);
endmodule

/* test/ext_mem_if_pin_control_tb.sv */
// Self-checking bench of the pin control block with a slow-target model.
// Assumes inputs change at the falling edge and outputs settle before it.
`timescale 1ns/10ps
module ext_mem_if_pin_control_tb;
  import emc_pkg::*;
  logic clk, rst_n, req, wr, periph, hold, rdy, arq, done, ack, breq, drv, full, div, rd_n, oe_n, we_n, ff_n, pd_n;
  logic [31:0] addr;
  logic [2:0] lo;
  logic [1:0] sz, width, strap, dsel, src;
  logic [7:0] types, be_n, be_v;
  logic [3:0] rsel, wcyc, ce_n, ce_v;
  logic rd_s, oe_s, we_s, ff_s, pd_s, ack_e;
  int err_total, compares, cyc, stb;
  emc_pin_ctrl dut_u (.i_core_clk(clk), .i_reset_n(rst_n), .i_acc_req(req), .i_acc_write(wr),
    .i_ext_word_addr(addr), .i_acc_byte_lo(lo), .i_acc_size(sz), .i_acc_periph(periph),
    .o_acc_ready(arq), .o_acc_done(done), .i_space_types(types), .i_read_en_select(rsel),
    .i_mem_width(width), .i_async_ready_in(rdy), .i_host_hold_req(hold), .o_host_hold_ack(ack),
    .o_own_bus_req(breq), .o_bus_drive_en(drv), .i_clk_strap(strap), .i_clk_div_sel(dsel),
    .o_clk_src_sel(src), .o_mem_clk_out_full(full), .o_mem_clk_out_div(div),
    .o_space_enable_out_n(ce_n), .o_byte_select_out_n(be_n), .o_shared_rd_strobe_n(rd_n),
    .o_shared_oe_strobe_n(oe_n), .o_shared_we_strobe_n(we_n), .o_fifo_space_out_en_n(ff_n),
    .o_periph_transfer_strobe_n(pd_n));
  emc_mem_model model_u (.i_core_clk(clk), .i_reset_n(rst_n), .i_space_enable_out_n(ce_n),
    .i_space_types(types), .i_rd_n(rd_n), .i_we_n(we_n), .i_wait_cyc(wcyc), .o_async_ready_in(rdy));
  // Clock of 10 ns
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Print counts and verdict, then stop
  task automatic final_report();
    $display("errors=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Reset with a strap value; straps change after capture to show they are latched
  task automatic do_reset(input logic [1:0] s, input logic [1:0] e);
    @(negedge clk);
    rst_n = 1'b0;
    strap = s;
    repeat (12) @(negedge clk);
    chk({ce_n, be_n, rd_n, oe_n, we_n, ff_n, pd_n, ack, drv}, {4'hf, 8'hff, 5'h1f, 2'b01});
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    strap = ~s;
    @(negedge clk);
    chk(src, e);
  endtask
  // One access; records which pins went low and how long it took
  task automatic acc(input logic [1:0] sp, input logic w, input logic [2:0] l, input logic [1:0] s,
    input logic p, input logic hq);
    int n;
    n = 0;
    @(negedge clk);
    req = 1'b1;
    wr = w;
    lo = l;
    sz = s;
    periph = p;
    addr = {2'b10, sp, 28'h0};
    // Let the ready output settle on the new address before looking at it
    #1;
    while (arq !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req = 1'b0;
    hold = hq;
    {ce_v, be_v, rd_s, oe_s, we_s, ff_s, pd_s, ack_e, cyc, stb} = {ce_n, be_n, 6'h0, 32'h1, 32'h0};
    while (cyc < 30 && n < 20) begin
      {rd_s, oe_s, we_s} = {rd_s, oe_s, we_s} | ~{rd_n, oe_n, we_n};
      {ff_s, pd_s, ack_e} = {ff_s, pd_s, ack_e} | {~ff_n, ~pd_n, ack};
      stb += (rd_n === 1'b0 || we_n === 1'b0) ? 1 : 0;
      if (done === 1'b1) break;
      @(negedge clk);
      cyc++;
    end
    if (cyc >= 30 || n >= 20) begin
      err_total++;
      final_report();
    end
  endtask
  // Sync accesses: read select roles, fifo enable, peripheral strobe
  task automatic t_sync();
    acc(2'h0, 1'b0, 3'h0, 2'h3, 1'b1, 1'b0);
    chk({ce_v, rd_s, oe_s, we_s, ff_s, pd_s}, {4'he, 5'b11001});
    chk(cyc, 3);
    acc(2'h0, 1'b1, 3'h0, 2'h3, 1'b0, 1'b0);
    chk({rd_s, oe_s, we_s, pd_s}, 4'b1010);
    acc(2'h3, 1'b1, 3'h0, 2'h3, 1'b0, 1'b0);
    chk({ce_v, rd_s, we_s}, {4'h7, 2'b01});
    acc(2'h3, 1'b0, 3'h0, 2'h3, 1'b0, 1'b0);
    chk({ff_s, rd_s, oe_s}, 3'b111);
  endtask
  // SDRAM row, column and write strobes
  task automatic t_sdram();
    acc(2'h2, 1'b0, 3'h0, 2'h3, 1'b0, 1'b0);
    chk({ce_v, rd_s, oe_s, we_s, ff_s}, {4'hb, 4'b1100});
    acc(2'h2, 1'b1, 3'h0, 2'h3, 1'b0, 1'b0);
    chk({rd_s, oe_s, we_s}, 3'b111);
  endtask
  // Async read at full speed, then write stretched by the slow target
  task automatic t_async();
    wcyc = 4'h0;
    acc(2'h1, 1'b0, 3'h0, 2'h3, 1'b0, 1'b0);
    chk({ce_v, rd_s, oe_s, we_s, cyc[3:0]}, {4'hd, 3'b110, 4'h4});
    wcyc = 4'h4;
    acc(2'h1, 1'b1, 3'h0, 2'h3, 1'b0, 1'b0);
    chk({we_s, stb >= 5}, 2'b11);
    wcyc = 4'h0;
  endtask
  // Byte lanes for several widths, offsets and sizes
  task automatic t_lanes();
    acc(2'h0, 1'b1, 3'h5, 2'h0, 1'b0, 1'b0);
    chk(be_v, 8'hdf);
    acc(2'h0, 1'b1, 3'h6, 2'h1, 1'b0, 1'b0);
    chk(be_v, 8'h3f);
    width = 2'h1;
    acc(2'h0, 1'b1, 3'h5, 2'h0, 1'b0, 1'b0);
    chk(be_v, 8'hfd);
    width = 2'h2;
    acc(2'h0, 1'b0, 3'h5, 2'h0, 1'b0, 1'b0);
    chk(be_v, 8'hf0);
    width = 2'h3;
  endtask
  // Hold raised mid-access: grant after the access, own request, release
  task automatic t_host();
    int n;
    acc(2'h0, 1'b0, 3'h0, 2'h3, 1'b0, 1'b1);
    chk(ack_e, 1'b0);
    for (n = 0; n < 4 && ack !== 1'b1; n++) @(negedge clk);
    // Grant never came: count it and stop
    if (ack !== 1'b1) begin
      err_total++;
      final_report();
    end
    chk({ack, drv}, 2'b10);
    req = 1'b1;
    @(negedge clk);
    chk({breq, arq}, 2'b10);
    hold = 1'b0;
    req = 1'b0;
    @(negedge clk);
    chk({ack, drv}, 2'b01);
    // An address outside the external window is never taken
    addr = {2'b01, 30'h0};
    #1;
    chk(arq, 1'b0);
  endtask
  // Output clock enables at each divisor
  task automatic t_clk();
    int t, f;
    for (int s = 0; s < 3; s++) begin
      dsel = s[1:0];
      repeat (4) @(negedge clk);
      t = 0;
      f = 0;
      repeat (16) begin
        @(negedge clk);
        t += (div === 1'b1) ? 1 : 0;
        f += (full === 1'b1) ? 1 : 0;
      end
      chk(t, 16 >> s);
      chk(f, 16);
    end
  endtask
  // Main sequence
  initial begin
    {rst_n, req, wr, periph, hold, addr, lo, sz, strap, dsel} = '0;
    {width, types, rsel, wcyc, err_total, compares} = {2'h3, 8'h92, 4'h8, 4'h0, 64'h0};
    do_reset(2'h1, SRC_CPU4);
    do_reset(2'h2, SRC_CPU6);
    do_reset(2'h0, SRC_PIN);
    t_sync();
    t_sdram();
    t_async();
    t_lanes();
    t_host();
    t_clk();
    final_report();
  end
endmodule
